// ===== rtl/mmdr_router.sv
// memory map decode router: steers core and io processor accesses
// assumes requesters hold their request while coreReady is low
//
// Contract
// - same-block core pair: data bus first, program bus one cycle later
// - core and io bus on one block both finish with no added cycle
// - block zero: nine 16-bit columns of 2K, 288K bits
// - block one: eight 16-bit columns of 2K, 256K bits
// - 64M-word space split into internal, multiprocessor and external parts
// - lowest 256 words are the local control registers
// - normal words: block zero 0x8000-0x9fff, block one 0xc000-0xdfff
// - short words: block zero 0x10000-0x13fff, block one 0x18000-0x1bfff
// - 0x20000 to 0x3ffffff goes to four external banks of 16M
// - bits 25-24 select external banks one to three, zero defers
// - bits 23-17 nonzero select an external bank
// - bits 16-15: registers, normal words or short words
// - bits 14-10 nonzero with register space selected are invalid
// - bits 9-8 pick local or peer registers, bits 7-0 the register
// - processor and select fields count only with bank and external zero
// - nonzero processor field: only the matching processor responds
// - own id in multiprocessor space is served locally, no system bus
// - multiprocessor self access is taken only from the core
// - invalid peer access: write dropped, read data undefined
// - program bus carries 24-bit addresses, data and io buses 32-bit
// - vector table occupies block zero normal words to 0x807f
// - io bus reaches everything except the local control registers
`timescale 1ns/1ps
`default_nettype none
module mmdr_router
  import mmdr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] procIdPin,
  input wire mmdr_pkg::mmdr_req_t dmReq,
  input wire mmdr_pkg::mmdr_req_t pmReq,
  input wire mmdr_pkg::mmdr_req_t ioReq,
  input wire mmdr_pkg::mmdr_req_t peerReq,
  output logic coreReady,
  output mmdr_pkg::mmdr_route_t dmRoute_q,
  output mmdr_pkg::mmdr_route_t pmRoute_q,
  output mmdr_pkg::mmdr_route_t ioRoute_q,
  output logic peerWrEn_q,
  output logic peerRdEn_q,
  output logic peerRdUndef_q,
  output logic [7:0] peerReg_q
);
  import mmdr_pkg::*;

  // full map decode shared by every bus
  function automatic mmdr_route_t decodeAddr(
    input mmdr_req_t req,
    input logic [1:0] myId,
    input logic fromCore
  );
    mmdr_route_t r;
    logic [1:0] v;
    logic [6:0] e;
    logic [1:0] s1;
    logic [4:0] s0;
    logic [1:0] m;
    r = '0;
    v = req.addr[V_HI:V_LO];
    e = req.addr[E_HI:E_LO];
    s1 = req.addr[S1_HI:S1_LO];
    s0 = req.addr[S0_HI:S0_LO];
    m = req.addr[M_HI:M_LO];
    r.valid = req.valid;
    r.write = req.write;
    r.word = req.addr[V_HI:0];
    r.region = RG_INVALID;
    if (!req.valid)
      r.region = RG_NONE;
    else if (req.addr[31:RSV_LO] != '0)
      r.region = RG_INVALID;
    else if (v != V_DEFER)
    begin
      r.region = RG_EXTERNAL;
      r.bank = v;
    end
    else if (e != '0)
    begin
      r.region = RG_EXTERNAL;
      r.bank = V_DEFER;
    end
    else if (s1 == S1_NORMAL)
    begin
      if (req.addr[S0_HI:NORM_HI+1] == NORM_B0)
      begin
        r.region = RG_NORMAL;
        r.block = 1'b0;
        r.vector = req.addr[NORM_HI:VEC_LO] == '0;
      end
      else if (req.addr[S0_HI:NORM_HI+1] == NORM_B1)
      begin
        r.region = RG_NORMAL;
        r.block = 1'b1;
      end
    end
    else if (s1 != S1_REGS)
    begin
      if (req.addr[S1_LO:S0_HI] == SHORT_B0)
        r.region = RG_SHORT;
      else if (req.addr[S1_LO:S0_HI] == SHORT_B1)
      begin
        r.region = RG_SHORT;
        r.block = 1'b1;
      end
      else if (req.addr[S1_LO:NORM_HI] == SHORT_COL9 && req.addr[0])
        r.region = RG_SHORT; // ninth column, odd words only
    end
    else if (s0 != '0)
      r.region = RG_INVALID;
    else if (m == M_LOCAL)
      r.region = RG_LOCAL_REG;
    else if (m == M_BAD)
      r.region = RG_INVALID;
    else if (m == myId)
      // self access kept off the system bus, core only
      r.region = fromCore ? RG_LOCAL_REG : RG_INVALID;
    else
    begin
      r.region = RG_PEER_REG;
      r.peer = m;
    end
    return r;
  endfunction : decodeAddr

  // true when a decoded access lands in an on-chip sram block
  function automatic logic inBlock(input mmdr_route_t r, input logic blk);
    return r.valid && (r.region == RG_NORMAL || r.region == RG_SHORT)
      && r.block == blk;
  endfunction : inBlock

  logic [1:0] idMeta_q;
  logic [1:0] id_q;
  logic pend_q;
  mmdr_route_t pmHold_q;
  mmdr_route_t dmDec;
  mmdr_route_t pmDec;
  mmdr_route_t ioDec;
  mmdr_route_t peerDec;
  mmdr_req_t pmWide;
  logic conflict;
  logic peerOk;

  // id pins are straps from outside; two flops before use
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      idMeta_q <= 2'h0;
      id_q <= 2'h0;
    end
    else
    begin
      idMeta_q <= procIdPin;
      id_q <= idMeta_q;
    end
  end

  // program bus only drives 24 bits, so it never reaches banks above
  assign pmWide = '{valid: pmReq.valid, write: pmReq.write,
    addr: {8'h00, pmReq.addr[PM_ADDR_W-1:0]}};

  assign dmDec = decodeAddr(dmReq, id_q, 1'b1);
  assign pmDec = decodeAddr(pmWide, id_q, 1'b1);
  // io bus may not touch local registers, own or via self id
  always_comb
  begin
    ioDec = decodeAddr(ioReq, id_q, 1'b0);
    if (ioDec.region == RG_LOCAL_REG)
      ioDec.region = RG_INVALID;
  end

  // core port is shared by both core buses; io port is separate
  assign conflict = !pend_q
    && ((inBlock(dmDec, 1'b0) && inBlock(pmDec, 1'b0))
    || (inBlock(dmDec, 1'b1) && inBlock(pmDec, 1'b1)));
  assign coreReady = !pend_q; // stall core in the added cycle

  // extra cycle marker and held program access
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pend_q <= 1'b0;
      pmHold_q <= '0;
    end
    else
    begin
      pend_q <= conflict;
      if (conflict)
        pmHold_q <= pmDec;
    end
  end

  // core routing: data bus wins, program bus follows a cycle later
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dmRoute_q <= '0;
      pmRoute_q <= '0;
    end
    else if (pend_q)
    begin
      dmRoute_q <= '0;
      pmRoute_q <= pmHold_q;
    end
    else
    begin
      dmRoute_q <= dmDec;
      pmRoute_q <= conflict ? '0 : pmDec;
    end
  end

  // io bus uses the second port and is never delayed
  always_ff @(posedge clk)
  begin
    if (!resetn)
      ioRoute_q <= '0;
    else
      ioRoute_q <= ioDec;
  end

  // incoming peer access: valid only for our id with upper fields clear
  assign peerDec = decodeAddr(peerReq, M_BAD, 1'b0);
  assign peerOk = peerDec.region == RG_PEER_REG && peerDec.peer == id_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      peerWrEn_q <= 1'b0;
      peerRdEn_q <= 1'b0;
      peerRdUndef_q <= 1'b0;
      peerReg_q <= 8'h00;
    end
    else
    begin
      peerWrEn_q <= peerReq.valid && peerReq.write && peerOk;
      peerRdEn_q <= peerReq.valid && !peerReq.write && peerOk;
      peerRdUndef_q <= peerReq.valid && !peerReq.write && !peerOk;
      peerReg_q <= peerReq.addr[P_HI:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence pairHit;
    conflict ##1 pend_q;
  endsequence

  dm_first_a: assert property (conflict
    |=> !pmRoute_q.valid && dmRoute_q.valid)
    else $error("data bus not first on block conflict");
  // judged in the cycle after the added one, so a new pair right after it stays legal
  pm_follows_a: assert property (pairHit
    |=> pmRoute_q.valid && !dmRoute_q.valid && !pend_q)
    else $error("program access not in one added cycle");
  // every io request answers next cycle, added core cycle or not
  io_no_stall_a: assert property (ioReq.valid
    |=> ioRoute_q.valid && ioRoute_q.write == $past(ioReq.write))
    else $error("io access delayed");
  local_regs_a: assert property (!pend_q && dmReq.valid
    && dmReq.addr[31:M_LO] == '0 |=> dmRoute_q.region == RG_LOCAL_REG)
    else $error("low 256 words not local registers");
  norm_b1_a: assert property (!pend_q && !conflict && dmReq.valid
    && dmReq.addr[31:S0_HI-1] == 19'h6
    |=> dmRoute_q.region == RG_NORMAL && dmRoute_q.block)
    else $error("normal block one misrouted");
  short_b1_a: assert property (!pend_q && !conflict && dmReq.valid
    && dmReq.addr[31:S0_HI] == 18'h6
    |=> dmRoute_q.region == RG_SHORT && dmRoute_q.block)
    else $error("short block one misrouted");
  ext_bank_a: assert property (!pend_q && dmReq.valid
    && dmReq.addr[31:RSV_LO] == '0 && dmReq.addr[V_HI:V_LO] != 2'h0
    |=> dmRoute_q.region == RG_EXTERNAL
    && dmRoute_q.bank == $past(dmReq.addr[V_HI:V_LO]))
    else $error("external bank misrouted");
  gap_bad_a: assert property (!pend_q && dmReq.valid
    && dmReq.addr[31:S1_LO] == '0 && dmReq.addr[S0_HI:S0_LO] != '0
    |=> dmRoute_q.region == RG_INVALID)
    else $error("gap address accepted");
  // block zero short words: eight plain columns, then odd words of the ninth
  b0_cols_a: assert property (dmRoute_q.region == RG_SHORT && !dmRoute_q.block
    |-> !dmRoute_q.word[S1_LO] && (!dmRoute_q.word[S0_HI]
    || (dmRoute_q.word[0] && dmRoute_q.word[S0_HI-1:NORM_HI] == '0)))
    else $error("short word outside block zero columns");
  // block one short words never run past its eight columns
  b1_cols_a: assert property (dmRoute_q.region == RG_SHORT && dmRoute_q.block
    |-> dmRoute_q.word[S0_HI:0] < B1_W16)
    else $error("short word outside block one columns");
  io_regs_a: assert property (ioRoute_q.region != RG_LOCAL_REG)
    else $error("io bus reached local registers");
  pm_narrow_a: assert property (pmRoute_q.word[V_HI:V_LO] == 2'h0)
    else $error("program bus reached upper banks");
  vec_tab_a: assert property (dmRoute_q.vector
    |-> dmRoute_q.region == RG_NORMAL && !dmRoute_q.block
    && dmRoute_q.word[NORM_HI:VEC_LO] == '0)
    else $error("vector flag outside table");
  peer_drop_a: assert property (peerReq.valid && !peerOk
    |=> !peerWrEn_q && !peerRdEn_q)
    else $error("invalid peer access served");
endmodule : mmdr_router
`default_nettype wire

// ===== rtl/mmdr_pkg.sv
// memory map decode router: shared field layout, map constants and carriers
// assumes the core (two buses) and io processor (one bus) present word addresses
package mmdr_pkg;
  // address field positions
  localparam int RSV_LO = 26;
  localparam int V_HI = 25;
  localparam int V_LO = 24;
  localparam int E_HI = 23;
  localparam int E_LO = 17;
  localparam int S1_HI = 16;
  localparam int S1_LO = 15;
  localparam int S0_HI = 14;
  localparam int S0_LO = 10;
  localparam int M_HI = 9;
  localparam int M_LO = 8;
  localparam int P_HI = 7;
  localparam int PM_ADDR_W = 24;
  // field codes
  localparam logic [1:0] V_DEFER = 2'h0;
  localparam logic [1:0] S1_REGS = 2'h0;
  localparam logic [1:0] S1_NORMAL = 2'h1;
  localparam logic [1:0] M_LOCAL = 2'h0;
  localparam logic [1:0] M_BAD = 2'h3;
  // block choice: normal uses bits 14-13, short uses bits 15-14
  localparam logic [1:0] NORM_B0 = 2'h0;
  localparam logic [1:0] NORM_B1 = 2'h2;
  localparam logic [1:0] SHORT_B0 = 2'h0;
  localparam logic [1:0] SHORT_B1 = 2'h2;
  // ninth column of block zero: odd short words at 0x14001..0x14fff
  localparam logic [3:0] SHORT_COL9 = 4'h4;
  // vector table: first 0x80 normal words of block zero
  localparam int VEC_LO = 7;
  localparam int NORM_HI = 12;
  // physical block shape
  localparam int COL_W = 16;
  localparam int COL_DEPTH = 2048;
  localparam int B0_COLS = 9;
  localparam int B1_COLS = 8;
  localparam int B0_BITS = B0_COLS * COL_W * COL_DEPTH;
  localparam int B1_BITS = B1_COLS * COL_W * COL_DEPTH;
  localparam int B0_W48 = (B0_COLS / 3) * COL_DEPTH;
  localparam int B1_W48 = (B1_COLS / 3) * COL_DEPTH;
  localparam int W32_WORDS = 4 * COL_DEPTH;
  localparam int B0_W16 = B0_COLS * COL_DEPTH;
  localparam int B1_W16 = B1_COLS * COL_DEPTH;

  typedef enum logic [2:0] {
    RG_NONE, RG_LOCAL_REG, RG_PEER_REG, RG_NORMAL,
    RG_SHORT, RG_EXTERNAL, RG_INVALID
  } mmdr_region_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } mmdr_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    mmdr_region_t region;
    logic block;
    logic [1:0] bank;
    logic [1:0] peer;
    logic vector;
    logic [25:0] word;
  } mmdr_route_t;
endpackage : mmdr_pkg

// ===== tb/mmdr_bus_model.sv
// bus model: core data/program buses, io processor bus and peer requester
// assumes coreReady is combinational and settled by the falling edge
`timescale 1ns/1ps
`default_nettype none
module mmdr_bus_model
  import mmdr_pkg::*;
(
  input wire logic clk,
  input wire logic coreReady,
  output mmdr_pkg::mmdr_req_t dmReq,
  output mmdr_pkg::mmdr_req_t pmReq,
  output mmdr_pkg::mmdr_req_t ioReq,
  output mmdr_pkg::mmdr_req_t peerReq
);
  // a released bus shows the inverse of its last address, never a stale copy
  function automatic mmdr_req_t rel(input mmdr_req_t r);
    rel = '{1'b0, ~r.write, ~r.addr};
  endfunction : rel

  // every bus idle from time zero
  initial
  begin
    dmReq = '0;
    pmReq = '0;
    ioReq = '0;
    peerReq = '0;
  end

  // one request per bus; held until an edge samples coreReady high
  task automatic send(input mmdr_req_t dm, input mmdr_req_t pm, input mmdr_req_t io,
                      input mmdr_req_t peer);
    logic taken;
    begin
      @(posedge clk);
      #1;
      if (dm.write && dm.addr >= 32'h300 && dm.addr < 32'h8000)
        dm.write = 1'b0;
      dmReq = dm;
      pmReq = pm;
      ioReq = io;
      peerReq = peer;
      taken = 1'b0;
      while (!taken)
      begin
        @(negedge clk);
        taken = coreReady;
        @(posedge clk);
      end
      #1;
      dmReq = rel(dm);
      pmReq = rel(pm);
      ioReq = rel(io);
      peerReq = rel(peer);
    end
  endtask : send
endmodule : mmdr_bus_model
`default_nettype wire

// ===== tb/mmdr_router_tb_top.sv
// testbench for the memory map decode router, one task per scenario
// assumes own processor id strap is 1 (2 after the mid-run reset) and
// requests go through the bus model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module mmdr_router_tb_top
  import mmdr_pkg::*;
;
  typedef struct packed {logic [31:0] a; mmdr_region_t r; logic [1:0] k; logic v;} mmdr_case_t;
  localparam mmdr_req_t IDLE = '0;
  // k holds the expected block, bank or peer; v the vector flag
  localparam mmdr_case_t TBL [22] = '{
    '{32'h5, RG_LOCAL_REG, 2'h0, 1'h0}, '{32'h105, RG_LOCAL_REG, 2'h0, 1'h0},
    '{32'h2a0, RG_PEER_REG, 2'h2, 1'h0}, '{32'h300, RG_INVALID, 2'h0, 1'h0},
    '{32'h400, RG_INVALID, 2'h0, 1'h0}, '{32'h8000, RG_NORMAL, 2'h0, 1'h1},
    '{32'h807f, RG_NORMAL, 2'h0, 1'h1}, '{32'h8080, RG_NORMAL, 2'h0, 1'h0},
    '{32'ha000, RG_INVALID, 2'h0, 1'h0}, '{32'hdfff, RG_NORMAL, 2'h1, 1'h0},
    '{32'he000, RG_INVALID, 2'h0, 1'h0}, '{32'h13fff, RG_SHORT, 2'h0, 1'h0},
    '{32'h14001, RG_SHORT, 2'h0, 1'h0}, '{32'h14002, RG_INVALID, 2'h0, 1'h0},
    '{32'h18000, RG_SHORT, 2'h1, 1'h0}, '{32'h1c000, RG_INVALID, 2'h0, 1'h0},
    '{32'h20000, RG_EXTERNAL, 2'h0, 1'h0}, '{32'hffffff, RG_EXTERNAL, 2'h0, 1'h0},
    '{32'h1000000, RG_EXTERNAL, 2'h1, 1'h0}, '{32'h2000000, RG_EXTERNAL, 2'h2, 1'h0},
    '{32'h3ffffff, RG_EXTERNAL, 2'h3, 1'h0}, '{32'h4000000, RG_INVALID, 2'h0, 1'h0}};
  logic clk;
  logic resetn;
  logic [1:0] procIdPin;
  logic coreReady;
  logic peerWrEn;
  logic peerRdEn;
  logic peerRdUndef;
  logic [7:0] peerReg;
  mmdr_req_t dmReq;
  mmdr_req_t pmReq;
  mmdr_req_t ioReq;
  mmdr_req_t peerReq;
  mmdr_route_t dmRoute;
  mmdr_route_t pmRoute;
  mmdr_route_t ioRoute;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  mmdr_bus_model bm (.clk(clk), .coreReady(coreReady), .dmReq(dmReq), .pmReq(pmReq),
    .ioReq(ioReq), .peerReq(peerReq));
  mmdr_router dut (.clk(clk), .resetn(resetn), .procIdPin(procIdPin), .dmReq(dmReq),
    .pmReq(pmReq), .ioReq(ioReq), .peerReq(peerReq), .coreReady(coreReady),
    .dmRoute_q(dmRoute), .pmRoute_q(pmRoute), .ioRoute_q(ioRoute), .peerWrEn_q(peerWrEn),
    .peerRdEn_q(peerRdEn), .peerRdUndef_q(peerRdUndef), .peerReg_q(peerReg));

  function automatic mmdr_req_t rq(input logic w, input logic [31:0] a);
    rq = '{1'b1, w, a};
  endfunction : rq

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // whole map through the data bus, boundaries of every region
  task automatic t_decode();
    mmdr_case_t c;
    foreach (TBL[i])
    begin
      c = TBL[i];
      bm.send(rq(1'b0, c.a), IDLE, IDLE, IDLE);
      `CHK(dmRoute.region, c.r)
      `CHK({dmRoute.valid, dmRoute.word}, {1'b1, c.a[25:0]})
      if (c.r == RG_NORMAL || c.r == RG_SHORT)
        `CHK(dmRoute.block, c.k[0])
      if (c.r == RG_EXTERNAL)
        `CHK(dmRoute.bank, c.k)
      if (c.r == RG_PEER_REG)
        `CHK(dmRoute.peer, c.k)
      if (c.r == RG_NORMAL)
        `CHK(dmRoute.vector, c.v)
    end
  endtask : t_decode

  // same block pair costs one cycle, data bus first; split blocks do not
  task automatic t_conflict();
    bm.send(rq(1'b0, 32'h8000), rq(1'b0, 32'h8001), rq(1'b0, 32'h8002), IDLE);
    `CHK({dmRoute.valid, pmRoute.valid, coreReady}, 3'h4)
    `CHK(ioRoute.region, RG_NORMAL)
    @(posedge clk);
    #1;
    `CHK({dmRoute.valid, pmRoute.valid, coreReady}, 3'h3)
    `CHK(pmRoute.region, RG_NORMAL)
    bm.send(rq(1'b1, 32'h8000), rq(1'b0, 32'h18000), IDLE, IDLE);
    `CHK({dmRoute.valid, pmRoute.valid, coreReady}, 3'h7)
    `CHK({dmRoute.write, pmRoute.write}, 2'h2)
  endtask : t_conflict

  // core and io on one block together: no added cycle
  task automatic t_dual();
    bm.send(rq(1'b0, 32'hc000), IDLE, rq(1'b1, 32'hc001), IDLE);
    `CHK({dmRoute.valid, ioRoute.valid, ioRoute.write, coreReady}, 4'hf)
    `CHK(ioRoute.region, RG_NORMAL)
  endtask : t_dual

  // program bus ignores everything above bit 23
  task automatic t_pm();
    bm.send(IDLE, rq(1'b0, 32'hff00c000), IDLE, IDLE);
    `CHK(pmRoute.region, RG_NORMAL)
    `CHK(pmRoute.block, 1'b1)
    `CHK(pmRoute.word, 26'hc000)
  endtask : t_pm

  // io bus is kept out of local registers, self window included
  task automatic t_io();
    logic [31:0] a [4] = '{32'h5, 32'h1ff, 32'h205, 32'h3000000};
    mmdr_region_t r [4] = '{RG_INVALID, RG_INVALID, RG_PEER_REG, RG_EXTERNAL};
    foreach (a[i])
    begin
      bm.send(IDLE, IDLE, rq(1'b0, a[i]), IDLE);
      `CHK(ioRoute.region, r[i])
    end
  endtask : t_io

  // peers: only our id window answers, bad reads flagged undefined
  task automatic t_peer();
    bm.send(IDLE, IDLE, IDLE, rq(1'b1, 32'h1ab));
    `CHK({peerWrEn, peerRdEn, peerRdUndef, peerReg}, 11'h4ab)
    bm.send(IDLE, IDLE, IDLE, rq(1'b0, 32'h1cd));
    `CHK({peerWrEn, peerRdEn, peerRdUndef, peerReg}, 11'h2cd)
    bm.send(IDLE, IDLE, IDLE, rq(1'b0, 32'h2cd));
    `CHK({peerWrEn, peerRdEn, peerRdUndef}, 3'h1)
    bm.send(IDLE, IDLE, IDLE, rq(1'b1, 32'h301));
    `CHK({peerWrEn, peerRdEn, peerRdUndef}, 3'h0)
  endtask : t_peer

  // reset dropped inside an added cycle, then the strap moves to id 2
  task automatic t_reset();
    bm.send(rq(1'b0, 32'h8000), rq(1'b0, 32'h8001), IDLE, IDLE);
    resetn = 1'b0;
    procIdPin = 2'h2;
    @(posedge clk);
    #1;
    `CHK({dmRoute.valid, pmRoute.valid, coreReady}, 3'h1)
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    bm.send(rq(1'b0, 32'h205), IDLE, IDLE, rq(1'b1, 32'h2ab));
    `CHK(dmRoute.region, RG_LOCAL_REG)
    `CHK({peerWrEn, peerRdEn, peerRdUndef, peerReg}, 11'h4ab)
    bm.send(rq(1'b0, 32'h105), IDLE, IDLE, IDLE);
    `CHK({dmRoute.region, dmRoute.peer}, {RG_PEER_REG, 2'h1})
  endtask : t_reset

  // free running clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard: the whole run needs about a hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  // reset, let the id strap settle, then the scenarios
  initial
  begin
    resetn = 1'b0;
    procIdPin = 2'h1;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    t_decode();
    t_conflict();
    t_dual();
    t_pm();
    t_io();
    t_peer();
    t_reset();
    stop_test();
  end
endmodule : mmdr_router_tb_top
`default_nettype wire
